// [src/esm_slave_fsm.v]
// slave communication state machine with service gating
`default_nettype none
`include "esm_consts.vh"

// Summary of operation
// - master requests state; slave reports result, error flag on failure
// - init: mailbox, process data in and out all disabled
// - pre-operational: mailbox only, no process data either way
// - safe-operational: mailbox plus input data sent, outputs ignored
// - operational: mailbox, reception and transmission all enabled
// - ascii jog-on/autotune ack only if cable open or init; jog-off always
// - panel jog and autotune run only if cable open or init
// - each one-step transition starts or stops its service
// - operational to pre-operational stops outputs and inputs, keeps mailbox
// - safe-operational to init stops inputs and mailbox
// - operational to init stops inputs, outputs and mailbox
// - bootstrap entered only from init; file download; exit restarts
// - download complete returns bootstrap to init
module esm_slave_fsm (
    input wire clock,
    input wire rst_b,
    input wire req_valid,
    input wire [3:0] req_state,
    input wire cable_open,
    input wire fw_download_done,
    input wire ascii_valid,
    input wire ascii_jog_on_cmd,
    input wire ascii_jog_off_cmd,
    input wire ascii_autotune_cmd,
    input wire panel_req,
    output reg [3:0] al_status_ff,
    output reg al_error_ff,
    output reg resp_valid_ff,
    output reg mbx_en_ff,
    output reg pd_rx_en_ff,
    output reg pd_tx_en_ff,
    output reg foe_en_ff,
    output reg device_restart_ff,
    output reg ascii_resp_valid_ff,
    output reg [7:0] ascii_resp_ff,
    output wire panel_allow
);
    // state codes live in the header; local names keep the decode short
    localparam [3:0] ST_INIT = `ESM_ST_INIT;
    localparam [3:0] ST_PREOP = `ESM_ST_PREOP;
    localparam [3:0] ST_BOOT = `ESM_ST_BOOT;
    localparam [3:0] ST_SAFEOP = `ESM_ST_SAFEOP;
    localparam [3:0] ST_OP = `ESM_ST_OP;
    localparam [7:0] ASCII_ACK = `ESM_ASCII_ACK;
    localparam [7:0] ASCII_CAN = `ESM_ASCII_CAN;

    // cable_open is a pin: two-stage synchroniser before use
    reg cable_s1_ff;
    reg cable_s2_ff;
    reg ok;
    reg [3:0] nxt_state;
    // next values of the status registers
    reg [3:0] nxt_status;
    reg nxt_error;
    reg nxt_resp_valid;
    reg nxt_restart;
    wire local_ok;
    wire in_init;
    wire in_preop;
    wire in_boot;
    wire in_safeop;
    wire in_op;
    wire boot_done;
    wire ascii_gated;
    wire ascii_cancel;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cable_s1_ff <= 1'b0;
            cable_s2_ff <= 1'b0;
        end else begin
            cable_s1_ff <= cable_open;
            cable_s2_ff <= cable_s1_ff;
        end
    end

    // one flag per state, shared by the decodes below other than the transition case
    assign in_init = (al_status_ff == ST_INIT);
    assign in_preop = (al_status_ff == ST_PREOP);
    assign in_boot = (al_status_ff == ST_BOOT);
    assign in_safeop = (al_status_ff == ST_SAFEOP);
    assign in_op = (al_status_ff == ST_OP);

    // local operation only while the network cannot command the drive;
    // the cable view lags the pin by the two synchroniser stages
    assign local_ok = cable_s2_ff | in_init;
    // panel asks, this block grants
    assign panel_allow = panel_req & local_ok;

    // legal transitions; same-state request is accepted as no change
    always @* begin
        ok = 1'b0;
        nxt_state = al_status_ff;
        case (al_status_ff)
            ST_INIT: begin
                case (req_state)
                    ST_INIT: ok = 1'b1;
                    ST_PREOP: ok = 1'b1;
                    ST_BOOT: ok = 1'b1;
                    default: ok = 1'b0;
                endcase
            end
            ST_PREOP: begin
                case (req_state)
                    ST_INIT: ok = 1'b1;
                    ST_PREOP: ok = 1'b1;
                    ST_SAFEOP: ok = 1'b1;
                    default: ok = 1'b0;
                endcase
            end
            ST_SAFEOP: begin
                case (req_state)
                    ST_INIT: ok = 1'b1;
                    ST_PREOP: ok = 1'b1;
                    ST_SAFEOP: ok = 1'b1;
                    ST_OP: ok = 1'b1;
                    default: ok = 1'b0;
                endcase
            end
            ST_OP: begin
                case (req_state)
                    ST_INIT: ok = 1'b1;
                    ST_PREOP: ok = 1'b1;
                    ST_SAFEOP: ok = 1'b1;
                    ST_OP: ok = 1'b1;
                    default: ok = 1'b0;
                endcase
            end
            ST_BOOT: begin
                // the only way out of bootstrap is back to init
                case (req_state)
                    ST_INIT: ok = 1'b1;
                    ST_BOOT: ok = 1'b1;
                    default: ok = 1'b0;
                endcase
            end
            default: ok = 1'b0;
        endcase
        if (ok) begin
            nxt_state = req_state;
        end
    end

    // download completion outranks a request in the same cycle,
    // so a late master request cannot hold the drive in bootstrap
    assign boot_done = in_boot & fw_download_done;

    always @* begin
        nxt_status = al_status_ff;
        nxt_error = al_error_ff;
        nxt_resp_valid = 1'b0;
        nxt_restart = 1'b0;
        if (boot_done) begin
            nxt_status = ST_INIT;
            nxt_restart = 1'b1;
        end else if (req_valid) begin
            nxt_resp_valid = 1'b1;
            nxt_error = ~ok;
            nxt_status = nxt_state;
            if (ok && in_boot && (req_state == ST_INIT)) begin
                nxt_restart = 1'b1;
            end
        end
    end

    // error level holds until the next request is evaluated
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            al_status_ff <= ST_INIT;
            al_error_ff <= 1'b0;
            resp_valid_ff <= 1'b0;
            device_restart_ff <= 1'b0;
        end else begin
            al_status_ff <= nxt_status;
            al_error_ff <= nxt_error;
            resp_valid_ff <= nxt_resp_valid;
            device_restart_ff <= nxt_restart;
        end
    end

    // service enables follow the state, so every multi-step exit
    // closes all services above the target in the same edge
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mbx_en_ff <= 1'b0;
            pd_rx_en_ff <= 1'b0;
            pd_tx_en_ff <= 1'b0;
            foe_en_ff <= 1'b0;
        end else begin
            mbx_en_ff <= in_preop | in_safeop | in_op;
            pd_tx_en_ff <= in_safeop | in_op;
            pd_rx_en_ff <= in_op;
            foe_en_ff <= in_boot;
        end
    end

    // motion commands are refused while the network owns the drive;
    // stopping motion is always safe, so jog-off is never refused
    assign ascii_gated = ascii_jog_on_cmd | ascii_autotune_cmd;
    assign ascii_cancel = ascii_gated & ~ascii_jog_off_cmd & ~local_ok;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ascii_resp_valid_ff <= 1'b0;
            ascii_resp_ff <= `ESM_ASCII_RST;
        end else begin
            ascii_resp_valid_ff <= ascii_valid;
            if (ascii_valid) begin
                if (ascii_cancel) begin
                    ascii_resp_ff <= ASCII_CAN;
                end else begin
                    ascii_resp_ff <= ASCII_ACK;
                end
            end
        end
    end
endmodule // esm_slave_fsm
`default_nettype wire

// [src/esm_consts.vh]
// constants for the slave communication state machine
`ifndef ESM_CONSTS_VH
`define ESM_CONSTS_VH
`define ESM_ST_INIT 4'h1
`define ESM_ST_PREOP 4'h2
`define ESM_ST_BOOT 4'h3
`define ESM_ST_SAFEOP 4'h4
`define ESM_ST_OP 4'h8
`define ESM_ASCII_ACK 8'h06
`define ESM_ASCII_CAN 8'h18
`define ESM_ASCII_RST 8'h00
`endif

// [bench/esm_master_model.sv]
// network master model: issues state requests
`default_nettype none
module esm_master_model (
    input wire logic clock,
    output var logic req_valid,
    output var logic [3:0] req_state
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {req_valid, req_state} = 5'h00;
    // request stands through the taking edge; caller samples the answer
    task issue(input logic [3:0] s);
        @(negedge clock) {req_valid, req_state} = {1'b1, s};
        @(posedge clock);
    endtask
    // released bus shows the inverse, not a stale value
    task drop;
        @(negedge clock) {req_valid, req_state} = {1'b0, ~req_state};
    endtask
endmodule // esm_master_model
`default_nettype wire

// [bench/esm_slave_fsm_properties.sv]
// assertions on the slave state machine ports
`default_nettype none
module esm_props (
    input wire logic clock, rst_b, req_valid, cable_open,
    input wire logic fw_download_done, ascii_valid, ascii_jog_on_cmd,
    input wire logic ascii_jog_off_cmd, al_error_ff, mbx_en_ff,
    input wire logic ascii_autotune_cmd,
    input wire logic pd_rx_en_ff, pd_tx_en_ff, resp_valid_ff,
    input wire logic device_restart_ff,
    input wire logic [3:0] req_state, al_status_ff,
    input wire logic [7:0] ascii_resp_ff
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire logic [2:0] en = {mbx_en_ff, pd_rx_en_ff, pd_tx_en_ff};
    wire logic [3:0] st = al_status_ff;
    property p_rsp; req_valid && !(st == 4'h3 && fw_download_done)
        |=> resp_valid_ff; endproperty
    a_rsp: assert property (p_rsp) else $error("no response");
    property p_ini; st == 4'h1 |=> en == 3'h0; endproperty
    a_ini: assert property (p_ini) else $error("init enables");
    property p_pre; st == 4'h2 |=> en == 3'h4; endproperty
    a_pre: assert property (p_pre) else $error("preop enables");
    property p_saf; st == 4'h4 |=> en == 3'h5; endproperty
    a_saf: assert property (p_saf) else $error("safeop enables");
    property p_op; st == 4'h8 |=> en == 3'h7; endproperty
    a_op: assert property (p_op) else $error("op enables");
    // sync delay: cable must have been closed for three edges
    property p_can; ascii_valid && (ascii_jog_on_cmd || ascii_autotune_cmd)
        && !ascii_jog_off_cmd && st != 4'h1 && !cable_open &&
        !$past(cable_open) && !$past(cable_open, 2)
        |=> ascii_resp_ff == 8'h18; endproperty
    a_can: assert property (p_can) else $error("jog not cancelled");
    property p_ack; ascii_valid && ascii_jog_off_cmd
        |=> ascii_resp_ff == 8'h06; endproperty
    a_ack: assert property (p_ack) else $error("jog-off refused");
    property p_err; st == 4'h2 && req_valid && req_state == 4'h3
        |=> st == 4'h2 && al_error_ff; endproperty
    a_err: assert property (p_err) else $error("boot from preop");
    property p_brq; st == 4'h3 && req_valid && req_state == 4'h1 &&
        !fw_download_done |=> st == 4'h1 && device_restart_ff; endproperty
    a_brq: assert property (p_brq) else $error("no restart");
    property p_bot; st == 4'h3 |-> $past(st) inside {4'h1, 4'h3};
    endproperty
    a_bot: assert property (p_bot) else $error("boot entry");
    property p_fw; st == 4'h3 && fw_download_done
        |=> st == 4'h1 && device_restart_ff; endproperty
    a_fw: assert property (p_fw) else $error("no return");
endmodule // esm_props
bind esm_slave_fsm esm_props i_esm_props (.clock(clock), .rst_b(rst_b),
    .req_valid(req_valid), .cable_open(cable_open),
    .fw_download_done(fw_download_done), .ascii_valid(ascii_valid),
    .ascii_jog_on_cmd(ascii_jog_on_cmd),
    .ascii_jog_off_cmd(ascii_jog_off_cmd),
    .ascii_autotune_cmd(ascii_autotune_cmd), .al_error_ff(al_error_ff),
    .mbx_en_ff(mbx_en_ff), .pd_rx_en_ff(pd_rx_en_ff),
    .pd_tx_en_ff(pd_tx_en_ff), .resp_valid_ff(resp_valid_ff),
    .device_restart_ff(device_restart_ff), .req_state(req_state),
    .al_status_ff(al_status_ff), .ascii_resp_ff(ascii_resp_ff));
`default_nettype wire

// [bench/fieldbus_slave_state_machine_test.sv]
// self-checking bench for the slave state machine
`default_nettype none
module fieldbus_slave_state_machine_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_b = 0, co = 0, fw = 0, av = 0;
    logic jn = 0, jf = 0, at = 0, pr = 0;
    logic [7:0] lf = 8'h52;
    logic [3:0] cur;
    logic [2:0] c;
    wire logic rq, err, rv, mb, rx, tx, foe, rs, arv, pa;
    wire logic [3:0] rs_st, st;
    wire logic [7:0] ar;
    int err_count = 0, checks = 0, cyc = 0;
    always #5 clock = ~clock;
    esm_master_model i_esm_master_model (.clock(clock), .req_valid(rq),
        .req_state(rs_st));
    esm_slave_fsm i_esm_slave_fsm (.clock(clock), .rst_b(rst_b),
        .req_valid(rq), .req_state(rs_st), .cable_open(co),
        .fw_download_done(fw), .ascii_valid(av), .ascii_jog_on_cmd(jn),
        .ascii_jog_off_cmd(jf), .ascii_autotune_cmd(at), .panel_req(pr),
        .al_status_ff(st), .al_error_ff(err), .resp_valid_ff(rv),
        .mbx_en_ff(mb), .pd_rx_en_ff(rx), .pd_tx_en_ff(tx), .foe_en_ff(foe),
        .device_restart_ff(rs), .ascii_resp_valid_ff(arv),
        .ascii_resp_ff(ar), .panel_allow(pa));
    task chk(input logic [11:0] g, e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    function logic [2:0] en(input logic [3:0] s);
        return s == 4'h8 ? 3'h7 : s == 4'h4 ? 3'h5 : s == 4'h2 ? 3'h4 : 3'h0;
    endfunction
    task go(input logic [3:0] s, e, input logic bad);
        i_esm_master_model.issue(s);
        #1 chk({rv, st, err}, {1'b1, e, bad});
        i_esm_master_model.drop;
        @(posedge clock) #1 chk({mb, rx, tx}, en(e));
    endtask
    task ask(input logic [2:0] k, input logic [7:0] e);
        @(negedge clock) {jn, jf, at, av} = {k, 1'b1};
        @(posedge clock) #1 chk({arv, ar}, {1'b1, e});
        @(negedge clock) av = 0;
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clock) if (++cyc > 3000) begin
        err_count++;
        wrap_up;
    end
    initial begin
        repeat (3) @(negedge clock);
        rst_b = 1;
        go(2, 2, 0); go(4, 4, 0); go(8, 8, 0); go(2, 2, 0);
        go(4, 4, 0); go(1, 1, 0); go(8, 1, 1);
        go(2, 2, 0); go(4, 4, 0); go(8, 8, 0); go(1, 1, 0);
        go(2, 2, 0); go(3, 2, 1);
        @(negedge clock) {co, pr} = 2'b11;
        repeat (3) @(posedge clock);
        ask(3'h4, 8'h06); chk(pa, 1);
        @(negedge clock) co = 0;
        repeat (3) @(posedge clock);
        ask(3'h4, 8'h18); chk(pa, 0);
        go(1, 1, 0); go(3, 3, 0); chk(foe, 1);
        @(negedge clock) fw = 1;
        @(posedge clock) #1 chk({rs, st}, 5'h11);
        @(negedge clock) fw = 0;
        go(3, 3, 0); go(1, 1, 0);
        cur = 1;
        repeat (12) begin
            lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
            if (lf[0]) begin
                cur = cur == 4'h1 ? 4'h2 : 4'h1;
                go(cur, cur, 0);
            end
            @(negedge clock) pr = lf[3];
            #1 chk(pa, lf[3] && cur == 4'h1);
            c = lf[2:1] == 2'h1 ? 3'h2 : lf[2:1] == 2'h2 ? 3'h1 : 3'h4;
            ask(c, (c[1] || cur == 4'h1) ? 8'h06 : 8'h18);
        end
        wrap_up;
    end
endmodule // fieldbus_slave_state_machine_test
`default_nettype wire
